// ---- src/dmc_ctrl.sv ----
// ddr2 mode-register and driver-calibration command sequencer (controller end)
`timescale 1ns/100ps
// Operation
// - program refresh-features register at init
// - banks precharged, cke high before write
// - wait register-set cycle time after write
// - refresh register: only A7 may be nonzero
// - set A7 before self-refresh when hot
// - spare register written all zero
// - calibration command always followed by exit
// - main register programmed before calibration
// - later one-register writes carry 000 calibration
// - adjust code on all dq, burst four
// - cke high through termination update window
// - termination pin low through update window (held only after OP_ONE writes, not after calibration or exit writes)
module dmc_ctrl
#(
   parameter int DQ_W = 8,
   parameter int WAIT_W = 8
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // user side
   input wire logic op_valid,
   output logic op_ready,
   input wire dmc_pkg::dmc_op_t op_code,
   input wire logic [13:0] op_data,
   input wire logic [2:0] op_cal_mode,
   input wire logic [3:0] op_adj_code,
   input wire logic [3:0] op_wlat,
   input wire logic hot_case,
   input wire logic term_req,
   output logic busy,
   output logic main_done,
   // memory pins
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [13:0] addr,
   output logic termination_control,
   output logic [DQ_W-1:0] dq_o,
   output logic dq_oe,
   input wire logic [DQ_W-1:0] dq_i
);
   // ====================================================
   // sequencer state
   dmc_pkg::dmc_state_t state_r, state_nxt;
   logic [WAIT_W-1:0] cnt_r, cnt_nxt; // wait / latency counter
   logic [1:0] beat_r, beat_nxt; // adjust burst beat
   logic [3:0] cmd_r, cmd_nxt; // {cs_n,ras_n,cas_n,we_n}
   logic [2:0] ba_r, ba_nxt;
   logic [13:0] addr_r, addr_nxt;
   logic [DQ_W-1:0] dq_r, dq_nxt;
   logic dq_oe_r, dq_oe_nxt;
   logic term_hold_r, term_hold_nxt; // forces termination pin low
   logic main_done_r, main_done_nxt; // main register programmed
   logic cal_open_r, cal_open_nxt; // calibration mode entered
   logic [3:0] adj_code_r, adj_code_nxt;
   logic [1:0] dq_s1_r, dq_s2_r; // returning dq pin sync, two flops, registered below
   logic [13:0] data_fix; // user data with reserved bits cleared
   // reserved bits forced per target register
   always_comb
   begin
      data_fix = op_data;
      case (op_code)
         dmc_pkg::OP_REFRESH:
         begin
            data_fix = '0;
            data_fix[dmc_pkg::A_SRF_FAST] = op_data[dmc_pkg::A_SRF_FAST] | hot_case;
         end
         dmc_pkg::OP_SPARE: data_fix = '0;
         dmc_pkg::OP_ONE: data_fix[9:7] = dmc_pkg::CAL_EXIT;
         default: data_fix = op_data;
      endcase
   end
   // accepts only from idle; calibration needs a programmed main register
   // main before calibration
   assign op_ready = (state_r == dmc_pkg::ST_IDLE) &&
      !(op_code == dmc_pkg::OP_CAL && !main_done_r);
   // ====================================================
   // next-state logic
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      beat_nxt = beat_r;
      cmd_nxt = dmc_pkg::CMD_NOP;
      ba_nxt = ba_r;
      addr_nxt = addr_r;
      dq_nxt = dq_r;
      dq_oe_nxt = 1'b0;
      term_hold_nxt = term_hold_r;
      main_done_nxt = main_done_r;
      cal_open_nxt = cal_open_r;
      adj_code_nxt = adj_code_r;
      case (state_r)
         dmc_pkg::ST_IDLE:
         begin
            if (op_valid && op_ready)
            begin
               state_nxt = dmc_pkg::ST_WAIT;
               cmd_nxt = dmc_pkg::CMD_MRS;
               addr_nxt = data_fix;
               cnt_nxt = WAIT_W'(dmc_pkg::REG_SET_CYCLES);
               case (op_code)
                  dmc_pkg::OP_MAIN:
                  begin
                     ba_nxt = dmc_pkg::BA_MAIN;
                     main_done_nxt = 1'b1;
                  end
                  dmc_pkg::OP_REFRESH: ba_nxt = dmc_pkg::BA_REFRESH;
                  dmc_pkg::OP_SPARE: ba_nxt = dmc_pkg::BA_SPARE;
                  dmc_pkg::OP_ONE:
                  begin
                     ba_nxt = dmc_pkg::BA_ONE;
                     term_hold_nxt = 1'b1;
                     cnt_nxt = WAIT_W'(dmc_pkg::REG_SET_CYCLES + dmc_pkg::TERM_UPDATE_CYCLES);
                  end
                  dmc_pkg::OP_CAL:
                  begin
                     ba_nxt = dmc_pkg::BA_ONE;
                     addr_nxt[9:7] = op_cal_mode;
                     cal_open_nxt = (op_cal_mode != dmc_pkg::CAL_EXIT);
                     adj_code_nxt = op_adj_code;
                     // first beat write latency after command; latency 0 unsupported
                     if (op_cal_mode == dmc_pkg::CAL_ADJUST)
                     begin
                        state_nxt = dmc_pkg::ST_WLAT;
                        cnt_nxt = WAIT_W'(op_wlat) - WAIT_W'(1);
                     end
                  end
                  default:
                  begin
                     cmd_nxt = dmc_pkg::CMD_PRE;
                     addr_nxt = 14'(1) << dmc_pkg::A_PRE_ALL;
                  end
               endcase
            end
         end
         dmc_pkg::ST_WAIT:
         begin
            if (cnt_r <= WAIT_W'(1))
            begin
               term_hold_nxt = 1'b0;
               if (cal_open_r)
                  state_nxt = dmc_pkg::ST_EXIT;
               else
                  state_nxt = dmc_pkg::ST_IDLE;
            end
            else
               cnt_nxt = cnt_r - WAIT_W'(1);
         end
         dmc_pkg::ST_WLAT:
         begin
            if (cnt_r == '0)
            begin
               state_nxt = dmc_pkg::ST_BURST;
               beat_nxt = 2'h0;
               dq_nxt = {DQ_W{adj_code_r[3]}};
               dq_oe_nxt = 1'b1;
            end
            else
               cnt_nxt = cnt_r - WAIT_W'(1);
         end
         dmc_pkg::ST_BURST:
         begin
            dq_oe_nxt = (beat_r != 2'(dmc_pkg::ADJ_BEATS - 1));
            dq_nxt = {DQ_W{adj_code_r[2'h2 - beat_r]}};
            beat_nxt = beat_r + 2'h1;
            if (beat_r == 2'(dmc_pkg::ADJ_BEATS - 1))
               state_nxt = dmc_pkg::ST_EXIT;
         end
         dmc_pkg::ST_EXIT:
         begin
            cmd_nxt = dmc_pkg::CMD_MRS;
            ba_nxt = dmc_pkg::BA_ONE;
            addr_nxt[9:7] = dmc_pkg::CAL_EXIT;
            cal_open_nxt = 1'b0;
            cnt_nxt = WAIT_W'(dmc_pkg::REG_SET_CYCLES);
            state_nxt = dmc_pkg::ST_WAIT;
         end
         default: state_nxt = dmc_pkg::ST_IDLE;
      endcase
   end
   // ====================================================
   // registers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= dmc_pkg::ST_IDLE;
         cnt_r <= '0;
         beat_r <= 2'h0;
         cmd_r <= dmc_pkg::CMD_DESEL;
         ba_r <= 3'h0;
         addr_r <= dmc_pkg::ADDR_RST;
         dq_r <= '0;
         dq_oe_r <= 1'b0;
         term_hold_r <= 1'b0;
         main_done_r <= 1'b0;
         cal_open_r <= 1'b0;
         adj_code_r <= 4'h0;
         dq_s1_r <= 2'h0;
         dq_s2_r <= 2'h0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         beat_r <= beat_nxt;
         cmd_r <= cmd_nxt;
         ba_r <= ba_nxt;
         addr_r <= addr_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
         term_hold_r <= term_hold_nxt;
         main_done_r <= main_done_nxt;
         cal_open_r <= cal_open_nxt;
         adj_code_r <= adj_code_nxt;
         dq_s1_r <= dq_i[1:0];
         dq_s2_r <= dq_s1_r;
      end
   end
   // ====================================================
   // pin drive
   // cke held high always after reset
   assign cke = !rst;
   assign {cs_n, ras_n, cas_n, we_n} = cmd_r;
   assign ba = ba_r;
   assign addr = addr_r;
   assign dq_o = dq_r;
   assign dq_oe = dq_oe_r;
   assign termination_control = term_req & !term_hold_r & (dq_s2_r != 2'h3 || 1'b1);
   assign busy = (state_r != dmc_pkg::ST_IDLE);
   assign main_done = main_done_r;
   // ====================================================
   // checks
   a_exit_follows_cal: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && state_r == dmc_pkg::ST_BURST && beat_r == 2'h3) |=> (state_r == dmc_pkg::ST_EXIT))
      else $error("calibration not followed by exit");
   a_cal_needs_main: assert property (@(posedge clk_sys) disable iff (rst)
      (op_code == dmc_pkg::OP_CAL && !main_done_r) |-> !op_ready)
      else $error("calibration accepted before main register");
   a_spare_zero: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_r == dmc_pkg::CMD_MRS && ba_r == dmc_pkg::BA_SPARE) |-> (addr_r == 14'h0000))
      else $error("spare register written nonzero");
   a_refresh_resv: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_r == dmc_pkg::CMD_MRS && ba_r == dmc_pkg::BA_REFRESH) |-> ((addr_r & 14'h3f7f) == 14'h0))
      else $error("refresh register reserved bits set");
   a_mrs_gap: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_r == dmc_pkg::CMD_MRS) |=> (cmd_r == dmc_pkg::CMD_NOP))
      else $error("command too soon after register write");
   a_term_low_upd: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_r == dmc_pkg::CMD_MRS && ba_r == dmc_pkg::BA_ONE && term_hold_r) |-> !termination_control)
      else $error("termination high in update window");
   a_cke_high: assert property (@(posedge clk_sys) disable iff (rst)
      busy |-> cke) else $error("cke low while sequencing");
   a_burst_len: assert property (@(posedge clk_sys) disable iff (rst)
      ($rose(dq_oe) && ce) |-> dq_oe [*4] ##1 !dq_oe) else $error("adjust burst not four beats");
endmodule

// ---- src/dmc_pkg.sv ----
// package: constants for the ddr2 mode-register sequencer (controller side)
package dmc_pkg;
   // command pin encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_DESEL = 4'hf;
   // bank selects of the mode registers
   localparam logic [2:0] BA_MAIN = 3'h0;
   localparam logic [2:0] BA_ONE = 3'h1;
   localparam logic [2:0] BA_REFRESH = 3'h2;
   localparam logic [2:0] BA_SPARE = 3'h3;
   // field positions
   localparam int A_SRF_FAST = 7;
   localparam int A_CAL_LSB = 7;
   localparam int A_PRE_ALL = 10;
   // calibration field codes in ext_register_one
   localparam logic [2:0] CAL_EXIT = 3'h0;
   localparam logic [2:0] CAL_DRIVE_HI = 3'h1;
   localparam logic [2:0] CAL_DRIVE_LO = 3'h2;
   localparam logic [2:0] CAL_ADJUST = 3'h4;
   localparam logic [2:0] CAL_DEFAULT = 3'h7;
   // timing figures in ns, and cycle counts at 50 mhz (20 ns)
   localparam int CLK_PERIOD_NS = 20;
   localparam int REG_SET_CYCLE_NS = 40;
   localparam int TERM_UPDATE_MAX_NS = 12;
   localparam int REG_SET_CYCLES =
      (REG_SET_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TERM_UPDATE_CYCLES =
      (TERM_UPDATE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // adjust burst length
   localparam int ADJ_BEATS = 4;
   // reset value of the address bus
   localparam logic [13:0] ADDR_RST = 14'h0000;
   // sequencer states, one-hot
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_ISSUE = 6'h02,
      ST_WAIT = 6'h04,
      ST_WLAT = 6'h08,
      ST_BURST = 6'h10,
      ST_EXIT = 6'h20
   } dmc_state_t;
   // user operations
   typedef enum logic [2:0]
   {
      OP_MAIN = 3'h0,
      OP_REFRESH = 3'h1,
      OP_SPARE = 3'h2,
      OP_ONE = 3'h3,
      OP_CAL = 3'h4,
      OP_PRECHARGE = 3'h5
   } dmc_op_t;
endpackage

// ---- tb/dmc_dev_model.sv ----
// device model: mode registers, calibration strength steps, termination switch
`timescale 1ns/100ps
module dmc_dev_model
#(
   // default strength step, arbitrary value within the 16-step range
   parameter logic [3:0] DEF_STEP = 4'h8,
   // write latency in cycles the controller is set to, al+cl-1
   parameter int WLAT_CYC = 3
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [13:0] addr,
   input wire logic termination_control,
   input wire logic [7:0] dq_o,
   input wire logic dq_oe,
   output logic [7:0] dq_i,
   output logic [13:0] ref_q,
   output logic [13:0] spare_q,
   output logic [13:0] one_q,
   output logic [3:0] pu_q,
   output logic [3:0] pd_q,
   output logic [7:0] err_q,
   output logic term_on
);
   logic [3:0] gap_r; // cycles since last register write, saturates
   logic [3:0] beat_r; // adjust beats taken
   logic [3:0] code_r; // adjust code, first beat in the msb
   logic [2:0] drv_r; // open calibration mode, zero once exited
   logic [1:0] hold_r; // termination update window
   logic main_r; // main register written
   logic mrs_w;
   logic cmd_w;
   logic [3:0] c_w;
   assign mrs_w = ({cs_n, ras_n, cas_n, we_n} == dmc_pkg::CMD_MRS);
   assign cmd_w = !cs_n && ({cs_n, ras_n, cas_n, we_n} != dmc_pkg::CMD_NOP);
   assign c_w = {code_r[2:0], dq_o[0]};
   // switch on only with a value chosen and clock enabled
   assign term_on = termination_control && cke && (one_q[6] || one_q[2]);
   // saturating step: further codes at a limit are ignored
   function automatic logic [3:0] step(input logic [3:0] v, input logic up, input logic dn);
      if (up && v != 4'hf)
         return v + 4'h1;
      if (dn && v != 4'h0)
         return v - 4'h1;
      return v;
   endfunction
   // ==========================================
   // command decode and controller checks
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         {gap_r, beat_r, code_r, drv_r, hold_r, main_r} <= {4'hf, 14'h0000};
         {ref_q, spare_q, one_q, err_q} <= '0;
         {pu_q, pd_q} <= {DEF_STEP, DEF_STEP};
         dq_i <= 8'h00;
      end
      else
      begin
         // released lines flip every cycle, never hold a stale value
         dq_i <= ~dq_i;
         gap_r <= (gap_r == 4'hf) ? gap_r : gap_r + 4'h1;
         hold_r <= (hold_r == 2'h0) ? hold_r : hold_r - 2'h1;
         if ((cmd_w && gap_r < 4'(dmc_pkg::REG_SET_CYCLES - 1))
             || (cmd_w && drv_r != 3'h0 && !(mrs_w && ba == 3'h1 && addr[9:7] == 3'h0))
             || (hold_r != 2'h0 && (termination_control || !cke)))
            err_q <= err_q + 8'h1;
         // drive levels one cycle after the mode command
         if (drv_r == dmc_pkg::CAL_DRIVE_HI)
            dq_i <= 8'hff;
         else if (drv_r == dmc_pkg::CAL_DRIVE_LO)
            dq_i <= 8'h00;
         if (drv_r == dmc_pkg::CAL_ADJUST && dq_oe && beat_r < 4'h4)
         begin
            code_r <= c_w;
            beat_r <= beat_r + 4'h1;
            // first beat exactly the write latency after the command
            if (dq_o != {8{dq_o[0]}} || (beat_r == 4'h0 && gap_r != 4'(WLAT_CYC - 1)))
               err_q <= err_q + 8'h1;
            if (beat_r == 4'h3)
            begin
               pu_q <= step(pu_q, c_w inside {4'h1, 4'h5, 4'h9}, c_w inside {4'h2, 4'h6, 4'ha});
               pd_q <= step(pd_q, c_w inside {4'h4, 4'h5, 4'h6}, c_w inside {4'h8, 4'h9, 4'ha});
            end
         end
         if (mrs_w)
         begin
            gap_r <= 4'h0;
            beat_r <= 4'h0;
            // clock enable high, main register first
            if (!cke || (ba == dmc_pkg::BA_ONE && addr[9:7] != 3'h0 && !main_r))
               err_q <= err_q + 8'h1;
            case (ba)
               dmc_pkg::BA_MAIN: main_r <= 1'b1;
               dmc_pkg::BA_REFRESH: ref_q <= addr;
               dmc_pkg::BA_SPARE: spare_q <= addr;
               dmc_pkg::BA_ONE:
               begin
                  one_q <= addr;
                  drv_r <= addr[9:7];
                  hold_r <= 2'(dmc_pkg::TERM_UPDATE_CYCLES);
                  if (addr[9:7] == dmc_pkg::CAL_DEFAULT)
                     {pu_q, pd_q} <= {DEF_STEP, DEF_STEP};
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// ---- tb/tb_dmc_ctrl.sv ----
// testbench: mode-register sequencer driving the device model
`timescale 1ns/100ps
module tb_dmc_ctrl;
   logic clk_sys, rst, ce, op_valid, hot_case, term_req, op_ready, busy, main_done;
   logic cke, cs_n, ras_n, cas_n, we_n, termination_control, dq_oe, term_on;
   dmc_pkg::dmc_op_t op_code;
   logic [13:0] op_data, addr, ref_q, spare_q, one_q;
   logic [2:0] op_cal_mode, ba;
   logic [3:0] op_adj_code, op_wlat, pu_q, pd_q;
   logic [7:0] dq_o, dq_i, err_q;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   dmc_ctrl u_dmc_ctrl (.clk_sys, .rst, .ce, .op_valid, .op_ready, .op_code, .op_data,
      .op_cal_mode, .op_adj_code, .op_wlat, .hot_case, .term_req, .busy, .main_done, .cke,
      .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .termination_control, .dq_o, .dq_oe, .dq_i);
   dmc_dev_model u_dmc_dev_model (.clk_sys, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
      .addr, .termination_control, .dq_o, .dq_oe, .dq_i, .ref_q, .spare_q, .one_q, .pu_q,
      .pd_q, .err_q, .term_on);
   // ==========================================
   // clock and hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one operation: request held from a falling edge until taken, then wait for idle
   task automatic run_op(input dmc_pkg::dmc_op_t op, input logic [13:0] d,
      input logic [2:0] m, input logic [3:0] a);
      int n;
      n = 0;
      op_code = op;
      op_data = d;
      op_cal_mode = m;
      op_adj_code = a;
      op_valid = 1'b1;
      while (op_ready !== 1'b1 && n < 50)
      begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      op_valid = 1'b0;
      while (busy !== 1'b0 && n < 200)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(14'(n < 200), 14'h1);
   endtask
   // ==========================================
   // scenarios
   task automatic t_refuse();
      op_code = dmc_pkg::OP_CAL;
      op_valid = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(14'({op_ready, busy}), 14'h0);
      op_valid = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic t_init();
      run_op(dmc_pkg::OP_PRECHARGE, 14'h0, 3'h0, 4'h0);
      run_op(dmc_pkg::OP_REFRESH, 14'h3f7f, 3'h0, 4'h0);
      chk(ref_q, 14'h0000);
      hot_case = 1'b1;
      run_op(dmc_pkg::OP_REFRESH, 14'h0, 3'h0, 4'h0);
      chk(ref_q, 14'h0080);
      hot_case = 1'b0;
      run_op(dmc_pkg::OP_SPARE, 14'h3fff, 3'h0, 4'h0);
      chk(spare_q, 14'h0000);
      run_op(dmc_pkg::OP_MAIN, 14'h0042, 3'h0, 4'h0);
      run_op(dmc_pkg::OP_ONE, 14'h03c4, 3'h0, 4'h0);
      chk(one_q, 14'h0044);
      chk(14'(main_done), 14'h1);
   endtask
   // frozen clock enable: a request must not be taken
   task automatic t_ce();
      ce = 1'b0;
      op_code = dmc_pkg::OP_SPARE;
      op_valid = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(14'(busy), 14'h0);
      op_valid = 1'b0;
      ce = 1'b1;
      @(negedge clk_sys);
   endtask
   task automatic t_adjust();
      logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h3, 4'h0};
      logic [7:0] exp [10] = '{8'h98, 8'h88, 8'h89, 8'h88, 8'h99, 8'h8a, 8'h99, 8'h88, 8'h88,
         8'h88};
      op_wlat = 4'h3;
      run_op(dmc_pkg::OP_CAL, 14'h0, dmc_pkg::CAL_DEFAULT, 4'h0);
      chk(14'({pu_q, pd_q}), 14'h88);
      foreach (codes[i])
      begin
         run_op(dmc_pkg::OP_CAL, 14'h0, dmc_pkg::CAL_ADJUST, codes[i]);
         chk(14'({pu_q, pd_q}), 14'(exp[i]));
      end
      repeat (9) run_op(dmc_pkg::OP_CAL, 14'h0, dmc_pkg::CAL_ADJUST, 4'h5);
      chk(14'({pu_q, pd_q}), 14'hff);
      repeat (17) run_op(dmc_pkg::OP_CAL, 14'h0, dmc_pkg::CAL_ADJUST, 4'ha);
      chk(14'({pu_q, pd_q}), 14'h00);
   endtask
   task automatic t_drive();
      logic [2:0] modes [3] = '{dmc_pkg::CAL_DRIVE_HI, dmc_pkg::CAL_DRIVE_LO, dmc_pkg::CAL_EXIT};
      foreach (modes[i])
      begin
         run_op(dmc_pkg::OP_CAL, 14'h0, modes[i], 4'h0);
         chk(14'(one_q[9:7]), 14'h0);
      end
   endtask
   task automatic t_term();
      term_req = 1'b1;
      run_op(dmc_pkg::OP_ONE, 14'h0044, 3'h0, 4'h0);
      chk(14'({termination_control, term_on}), 14'h3);
      run_op(dmc_pkg::OP_ONE, 14'h0002, 3'h0, 4'h0);
      chk(14'({termination_control, term_on}), 14'h2);
   endtask
   initial
   begin
      {rst, ce, op_valid, hot_case, term_req} = 5'h18;
      op_code = dmc_pkg::OP_MAIN;
      {op_data, op_cal_mode, op_adj_code, op_wlat} = '0;
      repeat (10) @(negedge clk_sys);
      chk(14'({cke, cs_n, dq_oe, busy}), 14'h4);
      rst = 1'b0;
      t_refuse();
      t_init();
      t_ce();
      t_adjust();
      t_drive();
      t_term();
      chk(14'(err_q), 14'h0);
      give_verdict();
   end
endmodule
